// [common/ctp_pkg.sv]
// Package: constants for the compare-toggle pulse generator
package ctp_pkg;
  // ********************
  // Register map (byte addresses)
  // ********************
  localparam logic [7:0] CTP_OFF_CTRL    = 8'h00;
  localparam logic [7:0] CTP_OFF_COMPARE = 8'h04;
  localparam logic [7:0] CTP_OFF_COUNT   = 8'h08;
  localparam logic [7:0] CTP_OFF_HIGH    = 8'h0c;
  localparam logic [7:0] CTP_OFF_LOW     = 8'h10;
  localparam logic [7:0] CTP_OFF_STATUS  = 8'h14;
  localparam logic [7:0] CTP_OFF_MASK    = 8'h18;
  localparam logic [7:0] CTP_OFF_FORCE   = 8'h1c;
  // ********************
  // Field positions
  // ********************
  localparam int CTP_BIT_AUTO  = 0;
  localparam int CTP_BIT_LEVEL = 1;
  localparam int CTP_BIT_PIN   = 2;
  localparam int CTP_BIT_MATCH = 0;
  // ********************
  // Reset values and timing
  // ********************
  localparam logic [15:0] CTP_RST_COMPARE = 16'hffff;
  localparam logic [15:0] CTP_RST_INTERVAL = 16'h0000;
  localparam int CTP_CLK_MHZ   = 100;
  localparam int CTP_TICK_US   = 2;
  localparam int CTP_TICK_CYC  = CTP_CLK_MHZ * CTP_TICK_US;
  localparam logic [7:0] CTP_TICK_LAST = 8'(CTP_TICK_CYC - 1);
  typedef enum logic [0:0] {CTP_IDLE = 1'b0, CTP_DATA = 1'b1} ctp_bus_t;
endpackage

// [logic/ctp_top.sv]
// Design: compare-toggle pulse generator with AHB-Lite registers
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// ********************
// Overview of operation
// ********************
// Overview of operation
// - Counter ticks once every two microseconds
// - Compare equal to count acts on pin
// - Match drives pin only when auto-enabled
// - Pin takes the compare level bit
// - Auto-enabled match inverts level, adds next interval
// - Each match sets status; IRQ rises only if mask bit set
module ctp_top (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Pulse output and interrupt
  output logic             PULSE_OUTPUT_PIN,
  output logic             IRQ
);
  import ctp_pkg::*;

  logic [7:0]  tick_cnt_r, tick_cnt_nxt;
  logic        tick;
  logic [15:0] free_running_count_r, free_running_count_nxt;
  logic [15:0] compare_value_reg_r, compare_value_reg_nxt;
  logic [15:0] high_r, high_nxt, low_r, low_nxt;
  logic        auto_output_enable_bit_r, auto_nxt;
  logic        compare_level_bit_r, level_nxt;
  logic        pin_r, pin_nxt;
  logic        status_r, status_nxt, mask_r, mask_nxt;
  logic        match;
  ctp_bus_t    ph_r, ph_nxt;
  logic        wr_r, wr_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        take;
  logic        wr_dp;

  // ********************
  // Timebase and comparator
  // ********************
  assign tick  = (tick_cnt_r == CTP_TICK_LAST);
  // Equality only on the tick, so one count value yields one match
  assign match = tick && (free_running_count_r == compare_value_reg_r);
  // Only whole-word single transfers are used; size and sequential codes are not decoded
  assign take  = HSEL && HREADY && HTRANS[1];
  // Write data follows its address by one cycle, so writes act in the data phase
  assign wr_dp = (ph_r == CTP_DATA) && wr_r;

  always_comb begin
    tick_cnt_nxt = tick ? 8'h00 : tick_cnt_r + 8'h01;
    free_running_count_nxt = tick ? free_running_count_r + 16'h0001
                                  : free_running_count_r;
  end

  // ********************
  // Bus, compare and pin logic
  // ********************
  always_comb begin
    ph_nxt   = take ? CTP_DATA : CTP_IDLE;
    wr_nxt   = take && HWRITE;
    addr_nxt = take ? HADDR[7:0] : addr_r;
    rdata_nxt = rdata_r;
    compare_value_reg_nxt = compare_value_reg_r;
    high_nxt  = high_r;
    low_nxt   = low_r;
    auto_nxt  = auto_output_enable_bit_r;
    level_nxt = compare_level_bit_r;
    pin_nxt   = pin_r;
    mask_nxt  = mask_r;
    status_nxt = status_r;
    // Read data is captured with the address so it stands through the data phase
    if (take && !HWRITE) begin
      case (HADDR[7:0])
        CTP_OFF_CTRL: begin
          rdata_nxt = {29'h0, pin_r, compare_level_bit_r, auto_output_enable_bit_r};
        end
        CTP_OFF_COMPARE: rdata_nxt = {16'h0, compare_value_reg_r};
        CTP_OFF_COUNT:   rdata_nxt = {16'h0, free_running_count_r};
        CTP_OFF_HIGH:    rdata_nxt = {16'h0, high_r};
        CTP_OFF_LOW:     rdata_nxt = {16'h0, low_r};
        CTP_OFF_STATUS:  rdata_nxt = {31'h0, status_r};
        CTP_OFF_MASK:    rdata_nxt = {31'h0, mask_r};
        default:         rdata_nxt = 32'h0;
      endcase
    end
    // Software writes land first; hardware events below override them
    if (wr_dp) begin
      case (addr_r)
        CTP_OFF_CTRL: begin
          auto_nxt  = HWDATA[CTP_BIT_AUTO];
          level_nxt = HWDATA[CTP_BIT_LEVEL];
        end
        CTP_OFF_COMPARE: compare_value_reg_nxt = HWDATA[15:0];
        CTP_OFF_HIGH:    high_nxt = HWDATA[15:0];
        CTP_OFF_LOW:     low_nxt  = HWDATA[15:0];
        CTP_OFF_STATUS:  if (HWDATA[CTP_BIT_MATCH]) status_nxt = 1'b0;
        CTP_OFF_MASK:    mask_nxt = HWDATA[CTP_BIT_MATCH];
        CTP_OFF_FORCE:   if (HWDATA[0]) pin_nxt = compare_level_bit_r;
        default: ;
      endcase
    end
    if (match) begin
      status_nxt = 1'b1;
      if (auto_output_enable_bit_r) begin
        pin_nxt = compare_level_bit_r;
        // Next interval follows the level just driven; wrap is intended
        level_nxt = ~compare_level_bit_r;
        compare_value_reg_nxt = compare_value_reg_r +
          (compare_level_bit_r ? high_r : low_r);
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      tick_cnt_r <= 8'h00;
      free_running_count_r <= 16'h0000;
      compare_value_reg_r <= CTP_RST_COMPARE;
      high_r <= CTP_RST_INTERVAL;
      low_r  <= CTP_RST_INTERVAL;
      auto_output_enable_bit_r <= 1'b0;
      compare_level_bit_r <= 1'b0;
      pin_r <= 1'b0;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      ph_r <= CTP_IDLE;
      wr_r <= 1'b0;
      addr_r <= 8'h00;
      rdata_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      free_running_count_r <= free_running_count_nxt;
      compare_value_reg_r <= compare_value_reg_nxt;
      high_r <= high_nxt;
      low_r  <= low_nxt;
      auto_output_enable_bit_r <= auto_nxt;
      compare_level_bit_r <= level_nxt;
      pin_r <= pin_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ph_r <= ph_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign HRDATA    = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign PULSE_OUTPUT_PIN = pin_r;
  // Level request: it stays up until software clears the sticky bit or masks it
  assign IRQ       = status_r && mask_r;

  // ********************
  // Assertions
  // ********************
  a_tick_period: assert property (@(posedge CLOCK) disable iff (!NRST)
    tick |-> ##200 tick) else $error("tick period wrong");
  a_count_step: assert property (@(posedge CLOCK) disable iff (!NRST)
    tick |=> free_running_count_r == $past(free_running_count_r) + 16'h0001)
    else $error("counter step wrong");
  a_match_pin: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && auto_output_enable_bit_r |=> pin_r == $past(compare_level_bit_r))
    else $error("pin not driven on match");
  a_auto_gate: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && !auto_output_enable_bit_r && !(ph_r == CTP_DATA && wr_r) |=> $stable(pin_r))
    else $error("pin moved while auto off");
  a_level_flip: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && auto_output_enable_bit_r |=> compare_level_bit_r != $past(compare_level_bit_r))
    else $error("level not inverted");
  a_next_compare: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && auto_output_enable_bit_r |=> compare_value_reg_r ==
      $past(compare_value_reg_r) + ($past(compare_level_bit_r) ? $past(high_r) : $past(low_r)))
    else $error("compare not advanced");
  a_irq_event: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && mask_r && !(wr_dp && addr_r == CTP_OFF_MASK) |=> IRQ) else $error("irq missing");
  a_force_quiet: assert property (@(posedge CLOCK) disable iff (!NRST)
    ph_r == CTP_DATA && wr_r && addr_r == CTP_OFF_FORCE && HWDATA[0] && !match
      && !status_r |=> pin_r == $past(compare_level_bit_r) && !status_r)
    else $error("force wrong");
  a_status_set: assert property (@(posedge CLOCK) disable iff (!NRST)
    match |=> status_r) else $error("status not set on match");
  a_status_clear: assert property (@(posedge CLOCK) disable iff (!NRST)
    wr_dp && addr_r == CTP_OFF_STATUS && HWDATA[CTP_BIT_MATCH] && !match |=> !status_r)
    else $error("status not cleared");
  a_count_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    !tick |=> $stable(free_running_count_r)) else $error("counter moved off tick");
  a_tick_bound: assert property (@(posedge CLOCK) disable iff (!NRST)
    tick_cnt_r <= CTP_TICK_LAST) else $error("tick divider out of range");
  a_pin_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    !match && !(wr_dp && addr_r == CTP_OFF_FORCE) |=> $stable(pin_r))
    else $error("pin moved without event");
  a_compare_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && !auto_output_enable_bit_r && !(wr_dp && addr_r == CTP_OFF_COMPARE)
      |=> $stable(compare_value_reg_r)) else $error("compare moved while auto off");
  a_level_hold: assert property (@(posedge CLOCK) disable iff (!NRST)
    match && !auto_output_enable_bit_r && !(wr_dp && addr_r == CTP_OFF_CTRL)
      |=> $stable(compare_level_bit_r)) else $error("level moved while auto off");

  // ********************
  // Coverage of main scenarios
  // ********************
  c_match_high: cover property (@(posedge CLOCK) match && compare_level_bit_r);
  c_match_low: cover property (@(posedge CLOCK) match && !compare_level_bit_r);
  c_irq: cover property (@(posedge CLOCK) IRQ);
  c_wrap: cover property (@(posedge CLOCK) tick && free_running_count_r == 16'hffff);
  c_force: cover property (@(posedge CLOCK) wr_dp && addr_r == CTP_OFF_FORCE && HWDATA[0]);
endmodule
`default_nettype wire

// [tb/ctp_rc_filter.sv]
// Partner model: RC filter averaging the pulse output
`timescale 1ns/1ps
`default_nettype none
module ctp_rc_filter (
  // Clock and pulse
  input  wire logic        clk,
  input  wire logic        pulse_in,
  // Averaged level
  output logic      [15:0] avg_level
);
  // First-order low pass; a shift of 8 stands in for the RC time constant
  logic [23:0] acc_r = 24'h000000;
  always_ff @(posedge clk) begin
    acc_r <= acc_r - (acc_r >> 8) + ((pulse_in === 1'b1) ? 24'h0000ff : 24'h000000);
  end
  assign avg_level = acc_r[23:8];
endmodule
`default_nettype wire

// [tb/tb.sv]
// Testbench: registers, compare toggling and interrupt of the pulse generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctp_pkg::*;
  logic        CLOCK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, rd_dp = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  wire logic [31:0] HRDATA;
  wire logic   HREADYOUT, HRESP, PIN, IRQ;
  wire logic [15:0] avg;
  logic [31:0] exp_q[$];
  localparam int PERIOD_CNT = 65000; // Timer counts in one pulse period
  logic [15:0] lo, hi;
  logic [7:0]  offs [8] = '{CTP_OFF_CTRL, CTP_OFF_COMPARE, CTP_OFF_COUNT, CTP_OFF_HIGH,
                            CTP_OFF_LOW, CTP_OFF_STATUS, CTP_OFF_MASK, 8'h40};
  int unsigned seed;
  int          err_total = 0, checked = 0, cyc = 0;
  ctp_top ctp_top_i (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PULSE_OUTPUT_PIN(PIN), .IRQ(IRQ));
  ctp_rc_filter ctp_rc_filter_i (.clk(CLOCK), .pulse_in(PIN), .avg_level(avg));
  always #5 CLOCK = ~CLOCK;
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_line(string n, logic e, logic g);
    cmp_word(n, {31'h0, e}, {31'h0, g});
  endtask
  // Starts after a rising edge; address held until hready, then data until hready again
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h000000, a};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_dp <= ~w;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 60000 && IRQ !== 1'b1; i++) @(posedge CLOCK);
    @(negedge CLOCK);
    cmp_line("irq raised", 1'b1, IRQ);
  endtask
  // Read data checked at the edge that ends the data phase
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (rd_dp && HREADYOUT === 1'b1 && exp_q.size() > 0)
      cmp_word("read data", exp_q.pop_front(), HRDATA);
    if (rd_dp && HREADYOUT === 1'b1)
      cmp_line("read response", 1'b0, HRESP);
    if (cyc > 70000) begin
      err_total++;
      give_verdict();
    end
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    seed = $urandom(30559);
    // Intervals keep the period sum and the 1/256 floor; the low one is random
    lo = 16'(PERIOD_CNT / 256 + 1) + 16'($urandom % 4);
    hi = 16'(PERIOD_CNT) - lo;
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    foreach (offs[i]) rd(offs[i], (offs[i] == CTP_OFF_COMPARE) ? 32'hffff : 32'h0);
    wr(CTP_OFF_HIGH, {16'h0, hi});
    wr(CTP_OFF_LOW, {16'h0, lo});
    wr(CTP_OFF_CTRL, 32'h3);
    wr(CTP_OFF_FORCE, 32'h1);
    wr(CTP_OFF_MASK, 32'h1);
    wr(CTP_OFF_CTRL, 32'h1);
    wr(CTP_OFF_COMPARE, 32'h3);
    rd(CTP_OFF_STATUS, 32'h0);
    @(negedge CLOCK);
    cmp_line("pin after force", 1'b1, PIN);
    wait_irq();
    cmp_line("pin at first match", 1'b0, PIN);
    rd(CTP_OFF_COMPARE, {16'h0, lo + 16'h3});
    rd(CTP_OFF_CTRL, 32'h3);
    wr(CTP_OFF_STATUS, 32'h1);
    @(negedge CLOCK);
    cmp_line("irq after clear", 1'b0, IRQ);
    wait_irq();
    cmp_line("pin at second match", 1'b1, PIN);
    rd(CTP_OFF_COMPARE, 32'(PERIOD_CNT + 3));
    rd(CTP_OFF_CTRL, 32'h5);
    wr(CTP_OFF_STATUS, 32'h1);
    wr(CTP_OFF_CTRL, 32'h0);
    wr(CTP_OFF_COMPARE, {16'h0, lo + 16'h6});
    wait_irq();
    cmp_line("irq with auto off", 1'b1, IRQ);
    cmp_line("pin with auto off", 1'b1, PIN);
    rd(CTP_OFF_COMPARE, {16'h0, lo + 16'h6});
    wr(CTP_OFF_MASK, 32'h0);
    @(negedge CLOCK);
    cmp_line("masked irq", 1'b0, IRQ);
    rd(CTP_OFF_STATUS, 32'h1);
    @(negedge CLOCK);
    cmp_line("filter average", 1'b1, avg > 16'h0080);
    repeat (2) @(posedge CLOCK);
    give_verdict();
  end
endmodule
`default_nettype wire
